/* File: hw/stcf_csr.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - trap pc bit zero always reads zero
// - no compressed support: low two bits zero
// - trap loads trap pc with faulting pc
// - cause: interrupt flag top, code below
// - cause code keeps only supported codes
// - interrupt codes 0,1,4,5,8,9 only
// - exception codes, priority in listed order
// - listed exceptions write fault address
// - other exceptions leave fault address alone
// - fetch fault address is faulting part
// - root holds page number and space id
// - 32-bit: id 31:22, page 21:0
// - 64-bit layout; not built here
// - unimplemented page bits read zero
// - space id width set by mask
// - decode fence from instruction fields
// - earlier stores before later walks
// - earlier implicit writes before later accesses
// - flush only local translation cache
// - nonzero id scopes flush to it
// - zero register source flushes all addresses
// - other source flushes leaf of address
module stcf_csr
  import stcf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trap_valid,
  input wire logic trap_is_irq,
  input wire logic [STCF_NUM_EXC-1:0] trap_exc_vec,
  input wire logic [STCF_NUM_IRQ-1:0] trap_irq_vec,
  input wire logic [31:0] trap_pc,
  input wire logic [31:0] trap_fault_addr,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] fence_address_source_value,
  input wire logic stores_drained,
  input wire logic implicit_writes_drained,
  output logic fence_busy,
  output logic fence_done,
  output logic tlb_flush,
  output logic tlb_flush_all_address_space_identifier,
  output logic tlb_flush_all_va,
  output logic [9:0] tlb_flush_address_space_identifier,
  output logic [31:0] tlb_flush_vaddr,
  output logic [9:0] address_space_identifier,
  output logic [21:0] root_ppn
);

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [1:0] {
    STCF_IDLE, STCF_DRAIN, STCF_FLUSH
  } stcf_state_t;

  logic [31:0] supervisor_trap_pc;
  logic [31:0] supervisor_trap_cause;
  logic [31:0] supervisor_fault_address;
  logic [31:0] supervisor_translation_root;
  logic compressed_en;
  logic [31:0] fence_count;
  stcf_state_t state;
  logic [9:0] held_address_space_identifier;
  logic [31:0] held_va;
  logic held_all_va;

  logic wr_en;
  logic [31:0] wmask;
  logic [31:0] pc_mask;
  logic [3:0] exc_code;
  logic exc_any;
  logic exc_sets_addr;
  logic [3:0] irq_code;
  logic code_ok;
  logic is_fence;

  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}},
    {8{pstrb[0]}}};
  assign pc_mask = compressed_en ? STCF_PC_MASK_COMP
    : STCF_PC_MASK_FULL;

  // ****************************************
  // exception and interrupt priority
  // ****************************************
  always_comb begin
    exc_code = STCF_EX_ECALL;
    exc_any = 1'b1;
    unique casez (trap_exc_vec)
      8'b???????1: exc_code = STCF_EX_FETCH_MISALIGN;
      8'b??????10: exc_code = STCF_EX_FETCH_ACCESS;
      8'b?????100: exc_code = STCF_EX_ILLEGAL;
      8'b????1000: exc_code = STCF_EX_BREAKPOINT;
      8'b???10000: exc_code = STCF_EX_LOAD_ACCESS;
      8'b??100000: exc_code = STCF_EX_AMO_MISALIGN;
      8'b?1000000: exc_code = STCF_EX_STORE_ACCESS;
      8'b10000000: exc_code = STCF_EX_ECALL;
      default: exc_any = 1'b0;
    endcase
  end

  // listed faults capture address; illegal and ecall do not
  assign exc_sets_addr = exc_any && (exc_code != STCF_EX_ILLEGAL)
    && (exc_code != STCF_EX_ECALL);

  always_comb begin
    irq_code = 4'h9;
    unique casez (trap_irq_vec)
      6'b1?????: irq_code = 4'h9;
      6'b01????: irq_code = 4'h8;
      6'b001???: irq_code = 4'h5;
      6'b0001??: irq_code = 4'h4;
      6'b00001?: irq_code = 4'h1;
      6'b000001: irq_code = 4'h0;
      default: irq_code = 4'h9;
    endcase
  end

  // supported codes for a software write of the cause register
  always_comb begin
    code_ok = 1'b0;
    if (pwdata[30:4] == 27'h000_0000) begin
      if (pwdata[STCF_INTR_BIT]) begin
        code_ok = (pwdata[3:0] == 4'h0) || (pwdata[3:0] == 4'h1)
          || (pwdata[3:0] == 4'h4) || (pwdata[3:0] == 4'h5)
          || (pwdata[3:0] == 4'h8) || (pwdata[3:0] == 4'h9);
      end else begin
        code_ok = (pwdata[3:0] <= STCF_EX_ECALL)
          && (pwdata[3:0] != 4'h4);
      end
    end
  end

  // ****************************************
  // trap program counter
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supervisor_trap_pc <= 32'h0000_0000;
    end else if (trap_valid) begin
      supervisor_trap_pc <= trap_pc & pc_mask;
    end else if (wr_en && paddr == STCF_TRAP_PC_ADDR) begin
      supervisor_trap_pc <= ((supervisor_trap_pc & ~wmask)
        | (pwdata & wmask)) & pc_mask;
    end
  end

  // ****************************************
  // cause
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supervisor_trap_cause <= 32'h0000_0000;
    end else if (trap_valid && (trap_is_irq || exc_any)) begin
      supervisor_trap_cause <= {trap_is_irq, 27'h000_0000,
        trap_is_irq ? irq_code : exc_code};
    end else if (wr_en && paddr == STCF_CAUSE_ADDR && code_ok) begin
      supervisor_trap_cause <= pwdata;
    end
  end

  // ****************************************
  // fault address
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supervisor_fault_address <= 32'h0000_0000;
    end else if (trap_valid && !trap_is_irq && exc_sets_addr) begin
      supervisor_fault_address <= trap_fault_addr;
    end else if (wr_en && paddr == STCF_FAULT_ADDR_ADDR) begin
      supervisor_fault_address <= (supervisor_fault_address & ~wmask)
        | (pwdata & wmask);
    end
  end

  // ****************************************
  // translation root
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supervisor_translation_root <= 32'h0000_0000;
    end else if (wr_en && paddr == STCF_ROOT_ADDR) begin
      supervisor_translation_root <= {
        pwdata[31:STCF_ADDRESS_SPACE_IDENTIFIER_LSB] & STCF_ADDRESS_SPACE_IDENTIFIER_IMPL_MASK,
        pwdata[STCF_ADDRESS_SPACE_IDENTIFIER_LSB-1:0] & STCF_PPN_IMPL_MASK};
    end
  end

  assign address_space_identifier =
    supervisor_translation_root[31:STCF_ADDRESS_SPACE_IDENTIFIER_LSB];
  assign root_ppn = supervisor_translation_root[STCF_ADDRESS_SPACE_IDENTIFIER_LSB-1:0];

  // ****************************************
  // configuration
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compressed_en <= 1'b0;
    end else if (wr_en && paddr == STCF_CONFIG_ADDR && pstrb[0]) begin
      compressed_en <= pwdata[0];
    end
  end

  // ****************************************
  // translation fence
  // ****************************************
  assign is_fence = instr_valid
    && instr_word[31:20] == STCF_FENCE_FUNCT12
    && instr_word[14:12] == STCF_PRIVILEGED_FUNCTION_CODE_FUNCT3
    && instr_word[11:7] == STCF_ZERO_REG
    && instr_word[6:0] == STCF_SYSTEM_OPCODE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= STCF_IDLE;
      held_address_space_identifier <= 10'h000;
      held_va <= 32'h0000_0000;
      held_all_va <= 1'b0;
    end else begin
      unique case (state)
        STCF_IDLE: begin
          if (is_fence) begin
            state <= STCF_DRAIN;
            held_address_space_identifier <= address_space_identifier;
            held_va <= fence_address_source_value;
            held_all_va <= instr_word[19:15] == STCF_ZERO_REG;
          end
        end
        STCF_DRAIN: begin
          if (stores_drained && implicit_writes_drained) begin
            state <= STCF_FLUSH;
          end
        end
        STCF_FLUSH: state <= STCF_IDLE;
      endcase
    end
  end

  // local-only flush request, scoped by space id and address
  assign fence_busy = state != STCF_IDLE;
  assign tlb_flush = state == STCF_FLUSH;
  assign fence_done = state == STCF_FLUSH;
  assign tlb_flush_all_address_space_identifier = held_address_space_identifier == 10'h000;
  assign tlb_flush_all_va = held_all_va;
  assign tlb_flush_address_space_identifier = held_address_space_identifier;
  assign tlb_flush_vaddr = held_va;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fence_count <= 32'h0000_0000;
    end else if (state == STCF_FLUSH) begin
      fence_count <= fence_count + 32'h0000_0001;
    end
  end

  // ****************************************
  // apb read and errors
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        STCF_TRAP_PC_ADDR: prdata <= supervisor_trap_pc & pc_mask;
        STCF_CAUSE_ADDR: prdata <= supervisor_trap_cause;
        STCF_FAULT_ADDR_ADDR: prdata <= supervisor_fault_address;
        STCF_ROOT_ADDR: prdata <= supervisor_translation_root;
        STCF_FENCE_STAT_ADDR: prdata <= fence_count;
        STCF_CONFIG_ADDR: prdata <= {31'h0000_0000, compressed_en};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      pslverr = !(paddr == STCF_TRAP_PC_ADDR || paddr == STCF_CAUSE_ADDR
        || paddr == STCF_FAULT_ADDR_ADDR || paddr == STCF_ROOT_ADDR
        || paddr == STCF_CONFIG_ADDR
        || (paddr == STCF_FENCE_STAT_ADDR && !pwrite));
    end
  end

endmodule

/* File: pkg/stcf_pkg.sv */
package stcf_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] STCF_TRAP_PC_ADDR = 12'h000;
  localparam logic [11:0] STCF_CAUSE_ADDR = 12'h004;
  localparam logic [11:0] STCF_FAULT_ADDR_ADDR = 12'h008;
  localparam logic [11:0] STCF_ROOT_ADDR = 12'h00C;
  localparam logic [11:0] STCF_FENCE_STAT_ADDR = 12'h010;
  localparam logic [11:0] STCF_CONFIG_ADDR = 12'h014;

  localparam int STCF_XLEN = 32;
  localparam int STCF_CODE_W = 31;
  localparam int STCF_INTR_BIT = 31;
  localparam int STCF_ADDRESS_SPACE_IDENTIFIER_LSB = 22;
  localparam int STCF_ADDRESS_SPACE_IDENTIFIER_W = 10;
  localparam int STCF_PPN_W = 22;

  // implemented widths; upper bits stay zero
  localparam logic [9:0] STCF_ADDRESS_SPACE_IDENTIFIER_IMPL_MASK = 10'h0FF;
  localparam logic [21:0] STCF_PPN_IMPL_MASK = 22'h0F_FFFF;

  localparam logic [31:0] STCF_PC_MASK_COMP = 32'hFFFF_FFFE;
  localparam logic [31:0] STCF_PC_MASK_FULL = 32'hFFFF_FFFC;

  // ****************************************
  // cause codes
  // ****************************************
  localparam logic [3:0] STCF_EX_FETCH_MISALIGN = 4'h0;
  localparam logic [3:0] STCF_EX_FETCH_ACCESS = 4'h1;
  localparam logic [3:0] STCF_EX_ILLEGAL = 4'h2;
  localparam logic [3:0] STCF_EX_BREAKPOINT = 4'h3;
  localparam logic [3:0] STCF_EX_LOAD_ACCESS = 4'h5;
  localparam logic [3:0] STCF_EX_AMO_MISALIGN = 4'h6;
  localparam logic [3:0] STCF_EX_STORE_ACCESS = 4'h7;
  localparam logic [3:0] STCF_EX_ECALL = 4'h8;
  localparam int STCF_NUM_EXC = 8;
  localparam int STCF_NUM_IRQ = 6;

  // ****************************************
  // fence instruction fields
  // ****************************************
  localparam logic [11:0] STCF_FENCE_FUNCT12 = 12'h104;
  localparam logic [2:0] STCF_PRIVILEGED_FUNCTION_CODE_FUNCT3 = 3'h0;
  localparam logic [6:0] STCF_SYSTEM_OPCODE = 7'h73;
  localparam logic [4:0] STCF_ZERO_REG = 5'h00;
endpackage

/* File: testbench/stcf_csr_asserts.sv */
`timescale 1ns/1ns
module stcf_csr_chk
  import stcf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic stores_drained,
  input wire logic implicit_writes_drained,
  input wire logic fence_busy,
  input wire logic fence_done,
  input wire logic tlb_flush,
  input wire logic tlb_flush_all_address_space_identifier,
  input wire logic [9:0] address_space_identifier,
  input wire logic [21:0] root_ppn
);
  // ****************************************
  // bus and fence checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_take;
    instr_valid && !fence_busy && instr_word[31:20] == STCF_FENCE_FUNCT12
      && instr_word[14:12] == STCF_PRIVILEGED_FUNCTION_CODE_FUNCT3
      && instr_word[11:7] == STCF_ZERO_REG
      && instr_word[6:0] == STCF_SYSTEM_OPCODE;
  endsequence
  sequence s_ready;
    fence_busy && !tlb_flush && stores_drained && implicit_writes_drained;
  endsequence
  property p_take; s_take |=> fence_busy; endproperty
  property p_early; s_take |=> !tlb_flush; endproperty
  property p_drain;
    fence_busy && !(stores_drained && implicit_writes_drained) |=> !tlb_flush;
  endproperty
  property p_flush; s_ready |=> tlb_flush; endproperty
  property p_pair; tlb_flush |-> fence_done ##1 !tlb_flush; endproperty
  property p_address_space_identifier;
    tlb_flush |-> tlb_flush_all_address_space_identifier == (address_space_identifier == 10'h000);
  endproperty
  property p_mask;
    (address_space_identifier & ~STCF_ADDRESS_SPACE_IDENTIFIER_IMPL_MASK) == 10'h000
      && (root_ppn & ~STCF_PPN_IMPL_MASK) == 22'h00_0000;
  endproperty
  property p_ready; pready; endproperty
  property p_slverr; psel && penable && paddr > 12'h014 |-> pslverr; endproperty
  a_take: assert property (p_take) else $error("fence not taken");
  a_early: assert property (p_early) else $error("flush too early");
  a_drain: assert property (p_drain) else $error("flush undrained");
  a_flush: assert property (p_flush) else $error("flush missing");
  a_pair: assert property (p_pair) else $error("flush pulse bad");
  a_address_space_identifier: assert property (p_address_space_identifier) else $error("address_space_identifier scope bad");
  a_mask: assert property (p_mask) else $error("root mask bad");
  a_ready: assert property (p_ready) else $error("ready low");
  a_slverr: assert property (p_slverr) else $error("no slave error");
endmodule
bind stcf_csr stcf_csr_chk u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .instr_valid(instr_valid), .instr_word(instr_word),
  .stores_drained(stores_drained), .fence_busy(fence_busy),
  .implicit_writes_drained(implicit_writes_drained),
  .fence_done(fence_done), .tlb_flush(tlb_flush),
  .tlb_flush_all_address_space_identifier(tlb_flush_all_address_space_identifier), .root_ppn(root_ppn),
  .address_space_identifier(address_space_identifier));

/* File: testbench/test_stcf_csr.sv */
`timescale 1ns/1ns
module test_stcf_csr
  import stcf_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er, irq;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, fa, pcv, ef;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, trap_valid = 0, trap_is_irq = 0;
  logic [7:0] trap_exc_vec = '0, ev;
  logic [5:0] trap_irq_vec = '0, iv;
  logic [31:0] trap_pc = '0, trap_fault_addr = '0, instr_word = '0;
  logic [31:0] fence_address_source_value = '0, tlb_flush_vaddr;
  logic instr_valid = 0, stores_drained = 0, implicit_writes_drained = 0;
  logic fence_busy, fence_done, tlb_flush, tlb_flush_all_address_space_identifier;
  logic tlb_flush_all_va;
  logic [9:0] tlb_flush_address_space_identifier, address_space_identifier;
  logic [21:0] root_ppn;
  int err_total = 0, n_compared = 0, cyc = 0;
  stcf_csr uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .trap_valid, .trap_is_irq,
    .trap_exc_vec, .trap_irq_vec, .trap_pc, .trap_fault_addr, .instr_valid,
    .instr_word, .fence_address_source_value, .stores_drained,
    .implicit_writes_drained, .fence_busy, .fence_done, .tlb_flush,
    .tlb_flush_all_address_space_identifier, .tlb_flush_all_va, .tlb_flush_address_space_identifier,
    .tlb_flush_vaddr, .address_space_identifier, .root_ppn);
  // ****************************************
  // helpers
  // ****************************************
  initial forever #5 pclk = ~pclk;
  task automatic report_and_stop;
    if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop;
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  function automatic logic [31:0] ecause(logic i, logic [7:0] e, logic [5:0] q);
    int c[8] = '{0, 1, 2, 3, 5, 6, 7, 8};
    int r[6] = '{0, 1, 4, 5, 8, 9};
    ecause = '0;
    if (i) begin
      for (int k = 0; k < 6; k++) if (q[k]) ecause = 32'h8000_0000 | 32'(r[k]);
    end else
      for (int k = 7; k >= 0; k--) if (e[k]) ecause = 32'(c[k]);
  endfunction
  task automatic fence(input logic [9:0] id, input logic [4:0] rs);
    int n;
    fa = $urandom;
    apb(1, STCF_ROOT_ADDR, {id, 22'h00_0000});
    stores_drained <= 0; implicit_writes_drained <= 0; instr_valid <= 1;
    instr_word <= {STCF_FENCE_FUNCT12, rs, STCF_PRIVILEGED_FUNCTION_CODE_FUNCT3, 5'h00,
      STCF_SYSTEM_OPCODE};
    fence_address_source_value <= fa;
    @(posedge pclk);
    fence_address_source_value <= ~fa;
    repeat (3) begin
      @(posedge pclk);
      chk(32'(tlb_flush), 0);
      chk(32'(fence_busy), 1);
      instr_valid <= 0;
    end
    stores_drained <= 1;
    repeat (2) begin @(posedge pclk); chk(32'(tlb_flush), 0); end
    implicit_writes_drained <= 1;
    n = 0;
    while (tlb_flush !== 1'b1 && n < 10) begin @(posedge pclk); n++; end
    chk(32'(tlb_flush), 1);
    chk(32'(fence_done), 1);
    chk(32'(tlb_flush_all_address_space_identifier), 32'(id == 0));
    if (id != 0) chk(32'(tlb_flush_address_space_identifier), 32'(id));
    chk(32'(tlb_flush_all_va), 32'(rs == 0));
    if (rs != 0) chk(tlb_flush_vaddr, fa);
    @(posedge pclk);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h3bfe5d34));
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    repeat (4) begin
      pcv = $urandom | 32'h3;
      apb(1, STCF_TRAP_PC_ADDR, pcv);
      apb(0, STCF_TRAP_PC_ADDR, 0);
      chk(rd, pcv & STCF_PC_MASK_FULL);
    end
    apb(1, STCF_CONFIG_ADDR, 32'h0000_0001);
    apb(1, STCF_TRAP_PC_ADDR, pcv);
    apb(0, STCF_TRAP_PC_ADDR, 0);
    chk(rd, pcv & STCF_PC_MASK_COMP);
    apb(0, STCF_CONFIG_ADDR, 0);
    chk(rd, 32'h0000_0001);
    apb(1, STCF_CONFIG_ADDR, 32'h0000_0000);
    apb(1, STCF_ROOT_ADDR, 32'hFFFF_FFFF);
    apb(0, STCF_ROOT_ADDR, 0);
    chk(rd, {STCF_ADDRESS_SPACE_IDENTIFIER_IMPL_MASK, STCF_PPN_IMPL_MASK});
    chk(32'(root_ppn), 32'(STCF_PPN_IMPL_MASK));
    apb(1, STCF_CAUSE_ADDR, 32'h8000_0009);
    apb(1, STCF_CAUSE_ADDR, 32'h0000_0004);
    apb(0, STCF_CAUSE_ADDR, 0);
    chk(rd, 32'h8000_0009);
    chk(32'(er), 0);
    apb(0, 12'h100, 0);
    chk(rd, 0);
    chk(32'(er), 1);
    apb(0, STCF_FAULT_ADDR_ADDR, 0);
    ef = rd;
    for (int i = 0; i < 40; i++) begin
      irq = (i >= 8 && i < 14) || (i >= 14 && $urandom_range(1));
      ev = (i < 8) ? 8'(1 << i) : 8'($urandom) | 8'h80;
      iv = (i >= 8 && i < 14) ? 6'(1 << (i - 8)) : 6'($urandom) | 6'h01;
      pcv = $urandom; fa = $urandom;
      trap_valid <= 1; trap_is_irq <= irq; trap_exc_vec <= ev;
      trap_irq_vec <= iv; trap_pc <= pcv; trap_fault_addr <= fa;
      @(posedge pclk);
      trap_valid <= 0;
      @(posedge pclk);
      if (!irq && (8'h7B & ev & (~ev + 8'h01)) != 0) ef = fa;
      apb(0, STCF_CAUSE_ADDR, 0);
      chk(rd, ecause(irq, ev, iv));
      apb(0, STCF_TRAP_PC_ADDR, 0);
      chk(rd, pcv & STCF_PC_MASK_FULL);
      apb(0, STCF_FAULT_ADDR_ADDR, 0);
      chk(rd, ef);
    end
    fence(10'h05, 5'h0B);
    fence(10'h000, STCF_ZERO_REG);
    instr_valid <= 1;
    instr_word <= {STCF_FENCE_FUNCT12, 13'h0080, STCF_SYSTEM_OPCODE};
    @(posedge pclk);
    instr_valid <= 0;
    @(posedge pclk);
    chk(32'(fence_busy), 0);
    apb(0, STCF_FENCE_STAT_ADDR, 0);
    chk(rd, 32'h0000_0002);
    chk(32'(er), 0);
    apb(1, STCF_FENCE_STAT_ADDR, 32'h0000_0000);
    chk(32'(er), 1);
    report_and_stop;
  end
endmodule
